// ---- serial_host_pkg.sv ----
/*
 * Shared constants and carrier types for the serial host controller.
 * Assumes a 100 MHz system clock; all timings are counted in its cycles.
 */
package serial_host_pkg;

	localparam int DGRAM_BITS = 32;
	localparam int CLK_PERIOD_NS = 10;

	// Device clock period in ns, then figures in device clock periods
	localparam int DEV_CLK_NS = 62;
	localparam int DEV_MIN_PHASE = 3;
	localparam int DEV_PERIOD_MULT = 8;
	localparam int SAFETY_MARGIN = 2;
	// Device clocks per serial clock period: 16 MHz device to a 1 MHz serial clock
	localparam int DEV_RATE_RATIO = 16;

	// Half serial clock period in our cycles; the rate limit is stricter than 8 per bit
	localparam int HALF_BIT_NS = DEV_CLK_NS * DEV_RATE_RATIO / 2;
	localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Guard times around select, rounded up with a margin
	localparam int GUARD_NS = DEV_CLK_NS * (DEV_MIN_PHASE + SAFETY_MARGIN);
	localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	// Register port map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_REQ = 4'h1;
	localparam logic [3:0] ADDR_REPLY = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IRQ = 4'h4;

	// Request layout
	localparam int REQ_SPACE_POS = 31;
	localparam int REQ_ADDR_HI = 30;
	localparam int REQ_ADDR_LO = 25;
	localparam int REQ_RW_POS = 24;
	localparam int DATA_W = 24;

	// Reply status layout
	localparam int RPL_IRQ_POS = 31;
	localparam int RPL_RIGHT_POS = 29;
	localparam int RPL_AUX_POS = 27;
	localparam int RPL_LEFT_POS = 25;
	localparam int RPL_TARGET_POS = 24;

	localparam logic [31:0] REPLY_RESET = 32'h0000_0000;

	typedef struct packed {
		logic memory_space_select;
		logic [5:0] addr;
		logic read_not_write;
		logic [DATA_W-1:0] data;
	} request_s;

	typedef struct packed {
		logic irq_active;
		logic rsvd30;
		logic right_switch;
		logic rsvd28;
		logic aux_input;
		logic rsvd26;
		logic left_switch;
		logic target_reached;
		logic [DATA_W-1:0] read_data;
	} reply_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_LEAD = 3'b010,
		ST_LOW = 3'b011,
		ST_HIGH = 3'b100,
		ST_TAIL = 3'b101,
		ST_GAP = 3'b110
	} link_state_e;

endpackage : serial_host_pkg

// ---- pin_sync.sv ----
/*
 * Three-stage synchroniser for one pin; a change counts once stages two and
 * three agree. Assumes the pin is asynchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic pin_i,
	output logic level_o
);

	logic stage1;
	logic stage2;
	logic stage3;
	wire logic agree = (stage2 == stage3);

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			stage1 <= RESET_LEVEL;
			stage2 <= RESET_LEVEL;
			stage3 <= RESET_LEVEL;
			level_o <= RESET_LEVEL;
		end
		else
		begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
			if (agree)
				level_o <= stage3;
		end
	end

endmodule : pin_sync

// ---- tick_divider.sv ----
/*
 * Enable pulse generator: one-cycle pulse every LENGTH cycles while run_i.
 * Assumes a single clock; restart_i realigns the phase.
 */
`timescale 1ns/1ns
module tick_divider #(
	parameter int LENGTH = 25,
	parameter int W = 8
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic restart_i,
	output logic tick_o
);

	logic [W-1:0] count;
	wire logic at_end = (count == W'(LENGTH - 1));
	wire logic [W-1:0] next_count = at_end ? '0 : count + W'(1);

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			count <= '0;
		else if (restart_i || !run_i)
			count <= '0;
		else
			count <= next_count;
	end

	assign tick_o = run_i && !restart_i && at_end;

endmodule : tick_divider

// ---- serial_host_ctrl.sv ----
/*
 * Host-side controller for the motion controller's four-wire serial port.
 * Software writes a request word and starts a 32-bit exchange; the reply
 * and the idle-time interrupt level are readable. Assumes a 100 MHz clock
 * and a device clock no slower than the one set in the package.
 */
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module serial_host_ctrl #(
	parameter int HALF_CYC = serial_host_pkg::HALF_BIT_CYC,
	parameter int GUARD_CYCLES = serial_host_pkg::GUARD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic host_select_n_o,
	output logic host_sclk_o,
	output logic host_serial_out_o,
	input wire logic serial_out_irq_pin_i,
	output logic busy_o,
	output logic irq_active_o
);

	localparam int W = serial_host_pkg::CNT_W;

	serial_host_pkg::link_state_e state;
	serial_host_pkg::link_state_e next_state;
	serial_host_pkg::request_s request;
	serial_host_pkg::reply_s reply;
	logic [31:0] shift_out;
	logic [31:0] shift_in;
	logic [5:0] bits_left;
	logic done_flag;
	logic pin_level;
	logic [W-1:0] guard_count;

	// Pin from the device is asynchronous to us
	pin_sync #(
		.RESET_LEVEL(1'b1)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.pin_i(serial_out_irq_pin_i),
		.level_o(pin_level)
	);

	wire logic in_phase = (state == serial_host_pkg::ST_LOW) ||
		(state == serial_host_pkg::ST_HIGH);
	wire logic restart_tick = (state != next_state);
	logic half_tick;

	// Half period of 8 device clocks keeps the rate cap and the 3-clock minimum
	tick_divider #(
		.LENGTH(HALF_CYC),
		.W(W)
	) u_half (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.run_i(in_phase),
		.restart_i(1'b0),
		.tick_o(half_tick)
	);

	wire logic guard_done = (guard_count == W'(GUARD_CYCLES - 1));
	wire logic reg_wr_ctrl = wr_i && (addr_i == serial_host_pkg::ADDR_CTRL);
	wire logic reg_wr_req = wr_i && (addr_i == serial_host_pkg::ADDR_REQ);
	wire logic start_req = reg_wr_ctrl && wdata_i[0] && (state == serial_host_pkg::ST_IDLE);
	wire logic last_bit = (bits_left == 6'd1);

	always_comb
	begin
		next_state = state;
		unique case (state)
			serial_host_pkg::ST_IDLE:
				if (start_req)
					next_state = serial_host_pkg::ST_SETUP;
			serial_host_pkg::ST_SETUP:
				if (guard_done)
					next_state = serial_host_pkg::ST_LEAD;
			serial_host_pkg::ST_LEAD:
				if (guard_done)
					next_state = serial_host_pkg::ST_LOW;
			serial_host_pkg::ST_LOW:
				if (half_tick)
					next_state = serial_host_pkg::ST_HIGH;
			serial_host_pkg::ST_HIGH:
				if (half_tick)
					next_state = last_bit ? serial_host_pkg::ST_TAIL : serial_host_pkg::ST_LOW;
			serial_host_pkg::ST_TAIL:
				if (guard_done)
					next_state = serial_host_pkg::ST_GAP;
			serial_host_pkg::ST_GAP:
				if (guard_done)
					next_state = serial_host_pkg::ST_IDLE;
			default:
				next_state = serial_host_pkg::ST_IDLE;
		endcase
	end

	wire logic guarded = (state == serial_host_pkg::ST_SETUP) ||
		(state == serial_host_pkg::ST_LEAD) || (state == serial_host_pkg::ST_TAIL) ||
		(state == serial_host_pkg::ST_GAP);
	wire logic [W-1:0] next_guard = (restart_tick || !guarded) ? '0 : guard_count + W'(1);

	// Reply sampled late in the high phase, well after the 3.5-clock valid time
	wire logic sample_now = (state == serial_host_pkg::ST_HIGH) && half_tick;

	// Reads ignore the data field, so send zeros there
	wire logic [31:0] req_word = wdata_i[serial_host_pkg::REQ_RW_POS] ?
		{wdata_i[31:serial_host_pkg::DATA_W], {serial_host_pkg::DATA_W{1'b0}}} :
		wdata_i;

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state <= serial_host_pkg::ST_IDLE;
			guard_count <= '0;
		end
		else
		begin
			state <= next_state;
			guard_count <= next_guard;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			request <= '0;
		else if (reg_wr_req && state == serial_host_pkg::ST_IDLE)
			request <= req_word;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift_out <= '0;
			shift_in <= '0;
			bits_left <= '0;
		end
		else if (start_req)
		begin
			shift_out <= request;
			bits_left <= 6'(serial_host_pkg::DGRAM_BITS);
		end
		else if (sample_now)
		begin
			shift_in <= {shift_in[30:0], pin_level};
			bits_left <= bits_left - 6'd1;
			// Next bit moves as the clock falls; last bit held until select rises
			if (!last_bit)
				shift_out <= {shift_out[30:0], 1'b0};
		end
	end

	// Reply latched as the transfer closes; set wins over software clear
	wire logic reply_done = (state == serial_host_pkg::ST_TAIL) && restart_tick;
	wire logic clear_done = rd_i && (addr_i == serial_host_pkg::ADDR_REPLY);

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			reply <= serial_host_pkg::REPLY_RESET;
			done_flag <= 1'b0;
		end
		else if (reply_done)
		begin
			reply <= shift_in;
			done_flag <= 1'b1;
		end
		else if (clear_done)
			done_flag <= 1'b0;
	end

	logic [31:0] next_rdata;
	always_comb
	begin
		unique case (addr_i)
			serial_host_pkg::ADDR_REQ: next_rdata = request;
			serial_host_pkg::ADDR_REPLY: next_rdata = reply;
			serial_host_pkg::ADDR_STATUS: next_rdata = {30'h0, done_flag, busy_o};
			serial_host_pkg::ADDR_IRQ: next_rdata = {31'h0, irq_active_o};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= '0;
		else if (rd_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= '0;
	end

	// Idle: select and clock both high; clock rises before select at the end
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			host_select_n_o <= 1'b1;
			host_sclk_o <= 1'b1;
			host_serial_out_o <= 1'b0;
			irq_active_o <= 1'b0;
		end
		else
		begin
			host_select_n_o <= (next_state == serial_host_pkg::ST_IDLE) ||
				(next_state == serial_host_pkg::ST_SETUP) ||
				(next_state == serial_host_pkg::ST_GAP);
			host_sclk_o <= (next_state != serial_host_pkg::ST_LOW);
			host_serial_out_o <= shift_out[31];
			// Pin carries inverted interrupt only while deselected
			if (host_select_n_o && state == serial_host_pkg::ST_IDLE)
				irq_active_o <= !pin_level;
		end
	end

	assign busy_o = (state != serial_host_pkg::ST_IDLE);

endmodule : serial_host_ctrl

// ---- serial_host_checker.sv ----
/* Port-level checks for serial_host_ctrl.
   Assumes only the top ports are visible; bound below. */
`timescale 1ns/1ns
module serial_host_checker #(
	parameter int HALF_CYC = 50,
	parameter int GUARD_CYCLES = 31
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic host_select_n_o,
	input wire logic host_sclk_o,
	input wire logic host_serial_out_o,
	input wire logic serial_out_irq_pin_i,
	input wire logic busy_o,
	input wire logic irq_active_o
);
	logic [1:0] pins_q;
	logic [7:0] run_cnt;
	logic [5:0] rise_cnt;
	wire logic sclk_up = !pins_q[0] && host_sclk_o;
	wire logic sclk_dn = pins_q[0] && !host_sclk_o;
	wire logic sel_up = !pins_q[1] && host_select_n_o;
	wire logic sel_dn = pins_q[1] && !host_select_n_o;
	wire logic moved = pins_q != {host_select_n_o, host_sclk_o};
	// Saturates so long idle spans never wrap to a short count
	wire logic [7:0] next_run = moved ? 8'h01 : run_cnt + {7'h0, run_cnt != 8'hff};
	wire logic [5:0] next_rise = sel_dn ? 6'h00 : rise_cnt + {5'h0, sclk_up};
	always_ff @(posedge clk_sys_i or negedge rstn_i)
		if (!rstn_i)
		begin
			pins_q <= 2'b11;
			run_cnt <= 8'h00;
			rise_cnt <= 6'h00;
		end
		else
		begin
			pins_q <= {host_select_n_o, host_sclk_o};
			run_cnt <= next_run;
			rise_cnt <= next_rise;
		end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	idle_lines_a: assert property (!busy_o |-> host_select_n_o && host_sclk_o)
		else $error("idle lines not high");
	sclk_low_a: assert property (sclk_up |-> run_cnt == HALF_CYC)
		else $error("clock low phase length");
	sclk_high_a: assert property (sclk_dn && rise_cnt != 6'h00 |-> run_cnt == HALF_CYC)
		else $error("clock high phase length");
	lead_time_a: assert property (sclk_dn && rise_cnt == 6'h00 |-> run_cnt >= GUARD_CYCLES)
		else $error("first clock fall too early");
	sel_setup_a: assert property (sel_dn |-> run_cnt >= GUARD_CYCLES)
		else $error("select high too short");
	sel_hold_a: assert property (sel_up |-> run_cnt >= GUARD_CYCLES)
		else $error("select rose too early");
	frame_len_a: assert property (sel_up |-> rise_cnt == 6'd32)
		else $error("frame not 32 bits");
	bit_hold_a: assert property (host_sclk_o && $past(host_sclk_o) && !host_select_n_o
		&& !$past(host_select_n_o) |-> $stable(host_serial_out_o))
		else $error("request bit moved while clock high");
	irq_follow_a: assert property (($stable(serial_out_irq_pin_i) && !busy_o) [*5]
		|-> irq_active_o == !serial_out_irq_pin_i)
		else $error("interrupt status not tracking pin");
	start_go_a: assert property (wr_i && addr_i == serial_host_pkg::ADDR_CTRL && wdata_i[0]
		&& !busy_o |=> busy_o)
		else $error("start not taken");
	unmapped_a: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	cover property (sel_up);
	cover property (wr_i && busy_o);
	cover property (irq_active_o && !busy_o);
endmodule : serial_host_checker

bind serial_host_ctrl serial_host_checker #(.HALF_CYC(HALF_CYC), .GUARD_CYCLES(GUARD_CYCLES))
	chk_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .host_select_n_o(host_select_n_o),
	.host_sclk_o(host_sclk_o), .host_serial_out_o(host_serial_out_o),
	.serial_out_irq_pin_i(serial_out_irq_pin_i), .busy_o(busy_o), .irq_active_o(irq_active_o));

// ---- serial_dev_model.sv ----
/* Behavioural far-end device of the serial link.
   Assumes the host keeps select and clock high while idle. */
`timescale 1ns/1ns
module serial_dev_model #(
	parameter int DLY_NS = 20
) (
	input wire logic select_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic irq_low_i,
	input wire logic [31:0] reply_i,
	output logic pin_o,
	output logic [31:0] req_o,
	output int frames_o
);
	logic [31:0] shift_q;
	logic tx_bit;
	int tx_idx;
	// Never floats: interrupt level while deselected
	assign pin_o = select_n_i ? irq_low_i : tx_bit;
	initial
	begin
		req_o = 32'h0;
		frames_o = 0;
		tx_bit = 1'b0;
		tx_idx = 1;
	end
	always @(negedge select_n_i)
	begin
		tx_idx = 32;
		tx_bit = ~tx_bit;
		shift_q = 32'h0;
	end
	always @(posedge sclk_i)
		if (!select_n_i)
			shift_q = {shift_q[30:0], sdi_i};
	// Old bit is scrambled until the new one is valid
	always @(negedge sclk_i)
		if (!select_n_i)
		begin
			tx_bit = ~tx_bit;
			#DLY_NS;
			tx_idx = tx_idx - 1;
			tx_bit = reply_i[tx_idx];
		end
	always @(posedge select_n_i)
		if (tx_idx == 0)
		begin
			req_o = shift_q;
			frames_o = frames_o + 1;
		end
endmodule : serial_dev_model

// ---- tb.sv ----
/* Self-checking bench for serial_host_ctrl against the device model.
   Assumes the model answers well inside one clock low phase. */
`timescale 1ns/1ns
module tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic sel_n;
	logic sclk;
	logic mosi;
	logic pin;
	logic busy;
	logic irq;
	logic irq_low = 1'b1;
	logic [31:0] reply_word = 32'h0;
	logic [31:0] dev_req;
	logic [31:0] val;
	int frames;
	int error_cnt = 0;
	int tests_run = 0;

	always #5 clk_sys = ~clk_sys;

	serial_host_ctrl #(.HALF_CYC(8), .GUARD_CYCLES(4)) dut_u (.clk_sys_i(clk_sys),
		.rstn_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .host_select_n_o(sel_n), .host_sclk_o(sclk),
		.host_serial_out_o(mosi), .serial_out_irq_pin_i(pin), .busy_o(busy),
		.irq_active_o(irq));
	serial_dev_model dev_u (.select_n_i(sel_n), .sclk_i(sclk), .sdi_i(mosi),
		.irq_low_i(irq_low), .reply_i(reply_word), .pin_o(pin), .req_o(dev_req),
		.frames_o(frames));

	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		d = rdata;
	endtask : reg_rd

	task automatic wait_idle();
		val = 32'h1;
		for (int i = 0; i < 400 && val[0] !== 1'b0; i++)
			reg_rd(serial_host_pkg::ADDR_STATUS, val);
	endtask : wait_idle

	task automatic xfer(input logic [31:0] req, input logic [31:0] rep, input logic [31:0] exp);
		reply_word <= rep;
		reg_wr(serial_host_pkg::ADDR_REQ, req);
		reg_wr(serial_host_pkg::ADDR_CTRL, 32'h1);
		reg_rd(serial_host_pkg::ADDR_STATUS, val);
		chk("busy", 32'h1, val);
		chk("busy port", 32'h1, {31'h0, busy});
		wait_idle();
		chk("device request", exp, dev_req);
		reg_rd(serial_host_pkg::ADDR_STATUS, val);
		chk("done", 32'h2, val);
		reg_rd(serial_host_pkg::ADDR_REPLY, val);
		chk("reply", rep, val);
		reg_rd(serial_host_pkg::ADDR_STATUS, val);
		chk("done cleared", 32'h0, val);
	endtask : xfer

	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		reg_rd(serial_host_pkg::ADDR_STATUS, val);
		chk("status reset", 32'h0, val);
		reg_rd(serial_host_pkg::ADDR_REPLY, val);
		chk("reply reset", serial_host_pkg::REPLY_RESET, val);
		reg_rd(4'hf, val);
		chk("unmapped", 32'h0, val);
		reg_rd(serial_host_pkg::ADDR_IRQ, val);
		chk("irq reset", 32'h0, val);
		$display("test reset done");
		xfer(32'h1a00_0123, 32'h9500_0123, 32'h1a00_0123);
		xfer(32'hffab_cdef, 32'h6a5a_5a5a, 32'hff00_0000);
		$display("test transfers done");
		// Orders given while busy must not disturb the running frame
		reg_wr(serial_host_pkg::ADDR_REQ, 32'h0200_0001);
		reg_wr(serial_host_pkg::ADDR_CTRL, 32'h1);
		reg_wr(serial_host_pkg::ADDR_REQ, 32'h7e00_00ff);
		reg_wr(serial_host_pkg::ADDR_CTRL, 32'h1);
		wait_idle();
		chk("frames", 32'd3, frames);
		chk("request kept", 32'h0200_0001, dev_req);
		$display("test refusal done");
		irq_low <= 1'b0;
		repeat (8) @(posedge clk_sys);
		reg_rd(serial_host_pkg::ADDR_IRQ, val);
		chk("irq set", 32'h1, val);
		chk("irq port", 32'h1, {31'h0, irq});
		irq_low <= 1'b1;
		repeat (8) @(posedge clk_sys);
		reg_rd(serial_host_pkg::ADDR_IRQ, val);
		chk("irq clear", 32'h0, val);
		$display("test irq done");
		test_done();
	end

	initial
	begin
		repeat (10000) @(posedge clk_sys);
		error_cnt++;
		test_done();
	end
endmodule : tb
